// *** include/pst_pkg.sv ***
// Constants shared by the 7:1 pixel serialiser.
// Assumes sys_clk is the seven-times bit clock of the link.
package pst_pkg;
  localparam int PST_LANES = 4;
  localparam int PST_SLOTS = 7;
  localparam int PST_WIDTH = 28;
  localparam int PST_CLK_HIGH_SLOTS = 4;
  localparam int PST_CLK_PERIOD_NS = 20;
  localparam int PST_LOCK_TIME_US = 10;
  localparam int PST_DISABLE_TIME_NS = 12;
  // Least time, rounded up
  localparam int PST_LOCK_CYC =
    (PST_LOCK_TIME_US * 1000 + PST_CLK_PERIOD_NS - 1) / PST_CLK_PERIOD_NS;
  // Longest time, rounded down, at least one cycle
  localparam int PST_DISABLE_CYC =
    (PST_DISABLE_TIME_NS / PST_CLK_PERIOD_NS) < 1 ? 1 :
    (PST_DISABLE_TIME_NS / PST_CLK_PERIOD_NS);
  // Input bit index sent by each lane in each slot
  localparam int PST_MAP [0:PST_LANES-1][0:PST_SLOTS-1] = '{
    '{1, 0, 7, 6, 4, 3, 2},
    '{9, 8, 18, 15, 14, 13, 12},
    '{20, 19, 26, 25, 24, 22, 21},
    '{5, 27, 23, 17, 16, 11, 10}
  };
  typedef enum logic [1:0] {
    PST_OFF,
    PST_ACQUIRE,
    PST_LOCKED
  } pst_lock_t;
endpackage

// *** include/pst_word_if.sv ***
// Carries the captured pixel word and load strobe between serialiser parts.
// Assumes a single clock domain.
`timescale 1ns/1ps
`default_nettype none
interface pst_word_if;
  logic load;
  logic clear;
  logic [27:0] word;
  modport src (output load, output word, input clear);
  modport snk (input load, input word, input clear);
endinterface
`default_nettype wire

// *** design/pst_capture.sv ***
// Samples the pixel clock and captures the pixel word on the selected edge.
// Assumes pixel inputs are synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module pst_capture (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic pixel_clock_in,
  input wire logic capture_edge_select,
  input wire logic [27:0] pixel_bits,
  pst_word_if.src cap
);
  logic pclk_q, pclk_d, prev_q, prev_d, load_q, load_d;
  logic [27:0] data_q, data_d, word_q, word_d;
  logic edge_hit;

  always_comb begin
    pclk_d = cap.clear ? 1'b0 : pixel_clock_in;
    prev_d = cap.clear ? 1'b0 : pclk_q;
    data_d = cap.clear ? 28'h0 : pixel_bits;
    // Rising edge when select high, falling when low
    edge_hit = capture_edge_select ? (pclk_q & ~prev_q) : (~pclk_q & prev_q);
    load_d = ~cap.clear & edge_hit;
    word_d = cap.clear ? 28'h0 : (edge_hit ? data_q : word_q);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pclk_q <= 1'b0;
      prev_q <= 1'b0;
      data_q <= 28'h0;
      load_q <= 1'b0;
      word_q <= 28'h0;
    end else begin
      pclk_q <= pclk_d;
      prev_q <= prev_d;
      data_q <= data_d;
      load_q <= load_d;
      word_q <= word_d;
    end
  end

  assign cap.load = load_q;
  assign cap.word = word_q;
endmodule
`default_nettype wire

// *** design/pst_lane_shift.sv ***
// One lane: parallel-load, serial-out shift register, slot 0 first.
// Assumes load pulses no more often than once per slot count.
`timescale 1ns/1ps
`default_nettype none
module pst_lane_shift #(
  parameter int SLOTS = 7
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic clear,
  input wire logic [SLOTS-1:0] slice,
  output logic lane_bit
);
  logic [SLOTS-1:0] sh_q, sh_d;

  always_comb begin
    if (clear) begin
      sh_d = '0;
    end else if (load) begin
      sh_d = slice;
    end else begin
      sh_d = {1'b0, sh_q[SLOTS-1:1]};
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sh_q <= '0;
    end else begin
      sh_q <= sh_d;
    end
  end

  assign lane_bit = sh_q[0];
endmodule
`default_nettype wire

// *** design/pst_serializer.sv ***
// Top of the 7:1 pixel serialiser: capture, lock tracking, four lanes and
// the forwarded clock. Assumes sys_clk runs at seven times the pixel clock.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Slot 0 sends bits 1, 9, 20, 5
// - Slot 1 sends bits 0, 8, 19, 27
// - Slot 2 sends bits 7, 18, 26, 23
// - Slot 3 sends bits 6, 15, 25, 17
// - Slot 4 sends bits 4, 14, 24, 16
// - Slot 5 sends bits 3, 13, 22, 11
// - Slot 6 sends bits 2, 12, 21, 10
// - Seven equal slots, slot 0 at clock rise
// - Forwarded clock high four slots, low three
// - Lanes valid only after lock time elapses
// - Shutdown turns forwarded clock driver off quickly
// - Capture edge chosen by edge-select input
// - Lanes run seven times the word rate
module pst_serializer
  import pst_pkg::*;
#(
  parameter int LANES = PST_LANES,
  parameter int SLOTS = PST_SLOTS
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic power_down_n,
  input wire logic pixel_clock_in,
  input wire logic capture_edge_select,
  input wire logic [27:0] pixel_bits,
  output logic [3:0] serial_lane,
  output logic serial_lane_oe,
  output logic forwarded_link_clock,
  output logic forwarded_link_clock_oe,
  output logic lanes_valid
);
  // Elaboration checks on sizes the logic can serve
  if (LANES != PST_LANES || SLOTS != PST_SLOTS || LANES * SLOTS != PST_WIDTH) begin : g_bad_sz
    $error("pst_serializer: lane and slot counts must be 4 and 7");
  end
  if (PST_CLK_HIGH_SLOTS >= SLOTS || PST_LOCK_CYC > 1024) begin : g_bad_time
    $error("pst_serializer: clock shape or lock count out of range");
  end

  pst_word_if wif ();
  pst_lock_t state_q, state_d;
  logic [2:0] slot_q, slot_d;
  logic [3:0] per_q, per_d;
  logic [9:0] lock_q, lock_d;
  logic fclk_q, fclk_d, oe_q, oe_d, valid_q, valid_d;
  logic run_q, run_d;
  logic period_ok, period_bad;
  logic [SLOTS-1:0] slice [0:LANES-1];

  assign wif.clear = ~power_down_n;

  pst_capture u_capture (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pixel_clock_in(pixel_clock_in),
    .capture_edge_select(capture_edge_select),
    .pixel_bits(pixel_bits),
    .cap(wif)
  );

  // Gather each lane's slice from the captured word
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      slice[l][0] = wif.word[PST_MAP[l][0]];
      slice[l][1] = wif.word[PST_MAP[l][1]];
      slice[l][2] = wif.word[PST_MAP[l][2]];
      slice[l][3] = wif.word[PST_MAP[l][3]];
      slice[l][4] = wif.word[PST_MAP[l][4]];
      slice[l][5] = wif.word[PST_MAP[l][5]];
      slice[l][6] = wif.word[PST_MAP[l][6]];
    end
  end

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    pst_lane_shift #(.SLOTS(SLOTS)) u_lane (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .load(wif.load),
      .clear(wif.clear),
      .slice(slice[g]),
      .lane_bit(serial_lane[g])
    );
  end

  // Slot counter, forwarded clock and period check
  always_comb begin
    period_ok = (per_q == 4'(SLOTS - 1));
    period_bad = (wif.load && !period_ok) || (per_q > 4'(SLOTS - 1));
    if (wif.clear) begin
      slot_d = 3'h0;
      per_d = 4'h0;
      fclk_d = 1'b0;
      run_d = 1'b0;
    end else if (wif.load) begin
      slot_d = 3'h0;
      per_d = 4'h0;
      fclk_d = 1'b1;
      run_d = 1'b1;
    end else begin
      slot_d = (slot_q == 3'(SLOTS - 1)) ? 3'h0 : slot_q + 3'h1;
      per_d = (per_q == 4'hf) ? per_q : per_q + 4'h1;
      // Held low until the first word, so no stretched first pulse
      fclk_d = run_q && (slot_d < 3'(PST_CLK_HIGH_SLOTS));
      run_d = run_q;
    end
  end

  // Lock tracking: waits the lock time with a steady period
  always_comb begin
    state_d = state_q;
    lock_d = lock_q;
    oe_d = 1'b1;
    valid_d = 1'b0;
    if (wif.clear) begin
      state_d = PST_OFF;
      lock_d = 10'h0;
      oe_d = 1'b0;
    end else begin
      unique case (state_q)
        PST_OFF: begin
          state_d = PST_ACQUIRE;
          lock_d = 10'h0;
        end
        PST_ACQUIRE: begin
          if (period_bad) begin
            lock_d = 10'h0;
          end else if (lock_q >= 10'(PST_LOCK_CYC - 1)) begin
            state_d = PST_LOCKED;
            valid_d = 1'b1;
          end else begin
            lock_d = lock_q + 10'h1;
          end
        end
        PST_LOCKED: begin
          valid_d = ~period_bad;
          if (period_bad) begin
            state_d = PST_ACQUIRE;
            lock_d = 10'h0;
          end
        end
        default: begin
          state_d = PST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      slot_q <= 3'h0;
      per_q <= 4'h0;
      fclk_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      slot_q <= slot_d;
      per_q <= per_d;
      fclk_q <= fclk_d;
      run_q <= run_d;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= PST_OFF;
      lock_q <= 10'h0;
      oe_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      lock_q <= lock_d;
      oe_q <= oe_d;
      valid_q <= valid_d;
    end
  end

  assign forwarded_link_clock = fclk_q;
  assign forwarded_link_clock_oe = oe_q;
  assign serial_lane_oe = oe_q;
  assign lanes_valid = valid_q;
endmodule
`default_nettype wire

// *** test/pst_serializer_assertions.sv ***
// Port checks for the 7:1 pixel serialiser.
// Assumes binding to pst_serializer, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module pst_serializer_assertions (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic power_down_n,
  input wire logic pixel_clock_in,
  input wire logic capture_edge_select,
  input wire logic [27:0] pixel_bits,
  input wire logic [3:0] serial_lane,
  input wire logic serial_lane_oe,
  input wire logic forwarded_link_clock,
  input wire logic forwarded_link_clock_oe,
  input wire logic lanes_valid
);
  logic [9:0] up_q;
  logic [27:0] w_q, w1_q, w2_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn || !power_down_n);
  // Cycles since shutdown released
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn || !power_down_n) up_q <= 10'h0;
    else if (up_q != 10'h3ff) up_q <= up_q + 10'h1;
  end
  always_ff @(posedge sys_clk) begin
    if (capture_edge_select ? $rose(pixel_clock_in) : $fell(pixel_clock_in)) w_q <= pixel_bits;
    w1_q <= w_q;
    w2_q <= w1_q;
  end
  sequence s_cap;
    lanes_valid && (capture_edge_select ? $rose(pixel_clock_in) : $fell(pixel_clock_in));
  endsequence
  sequence s_hi; forwarded_link_clock [*4]; endsequence
  sequence s_lo; !forwarded_link_clock [*3]; endsequence
  property p_slot0;
    s_cap |-> ##3 $rose(forwarded_link_clock) && serial_lane == {w_q[5], w_q[20], w_q[9], w_q[1]};
  endproperty
  a_slot0: assert property (p_slot0) else $error("slot 0 wrong");
  property p_slot1; s_cap |-> ##4 serial_lane == {w_q[27], w_q[19], w_q[8], w_q[0]}; endproperty
  a_slot1: assert property (p_slot1) else $error("slot 1 wrong");
  property p_slot2; s_cap |-> ##5 serial_lane == {w_q[23], w_q[26], w_q[18], w_q[7]}; endproperty
  a_slot2: assert property (p_slot2) else $error("slot 2 wrong");
  property p_slot3; s_cap |-> ##6 serial_lane == {w_q[17], w_q[25], w_q[15], w_q[6]}; endproperty
  a_slot3: assert property (p_slot3) else $error("slot 3 wrong");
  property p_slot4; s_cap |-> ##7 serial_lane == {w_q[16], w_q[24], w_q[14], w_q[4]}; endproperty
  a_slot4: assert property (p_slot4) else $error("slot 4 wrong");
  property p_slot5;
    s_cap |-> ##8 serial_lane == {w1_q[11], w1_q[22], w1_q[13], w1_q[3]};
  endproperty
  a_slot5: assert property (p_slot5) else $error("slot 5 wrong");
  property p_slot6;
    s_cap |-> ##9 serial_lane == {w2_q[10], w2_q[21], w2_q[12], w2_q[2]};
  endproperty
  a_slot6: assert property (p_slot6) else $error("slot 6 wrong");
  property p_shape; $rose(forwarded_link_clock) |-> s_hi ##1 s_lo ##1 forwarded_link_clock; endproperty
  a_shape: assert property (p_shape) else $error("clock shape wrong");
  property p_period; $rose(forwarded_link_clock) |-> ##7 $rose(forwarded_link_clock); endproperty
  a_period: assert property (p_period) else $error("clock period wrong");
  property p_off;
    disable iff (!resetn) !power_down_n |=> !forwarded_link_clock_oe && !serial_lane_oe &&
      !forwarded_link_clock && !lanes_valid && serial_lane == 4'h0;
  endproperty
  a_off: assert property (p_off) else $error("shutdown not off");
  property p_oe; power_down_n [*3] |-> forwarded_link_clock_oe && serial_lane_oe; endproperty
  a_oe: assert property (p_oe) else $error("driver not on");
  property p_lock_min; $rose(lanes_valid) |-> up_q >= 10'h1f4; endproperty
  a_lock_min: assert property (p_lock_min) else $error("lock too early");
  property p_lock_max; up_q == 10'h258 |-> lanes_valid; endproperty
  a_lock_max: assert property (p_lock_max) else $error("lock too late");
endmodule
bind pst_serializer pst_serializer_assertions i_chk (.sys_clk, .resetn, .power_down_n,
  .pixel_clock_in, .capture_edge_select, .pixel_bits, .serial_lane, .serial_lane_oe,
  .forwarded_link_clock, .forwarded_link_clock_oe, .lanes_valid);
`default_nettype wire

// *** test/pst_link_rx.sv ***
// Panel deserialiser model: rebuilds pixel words from the lanes.
// Assumes lanes and forwarded clock sampled on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module pst_link_rx (
  input wire logic sys_clk,
  input wire logic [3:0] serial_lane,
  input wire logic forwarded_link_clock,
  output logic [27:0] rx_word,
  output logic rx_stb
);
  // Bit index per slot, lanes 0 to 3
  localparam int M [28] = '{1, 9, 20, 5, 0, 8, 19, 27, 7, 18, 26, 23, 6, 15, 25, 17,
    4, 14, 24, 16, 3, 13, 22, 11, 2, 12, 21, 10};
  logic f_q = 1'b0;
  int k = 7;
  always @(posedge sys_clk) begin
    rx_stb <= 1'b0;
    if (forwarded_link_clock && !f_q) k = 0;
    if (k < 7) begin
      for (int l = 0; l < 4; l++) rx_word[M[4*k+l]] <= serial_lane[l];
      if (k == 6) rx_stb <= 1'b1;
      k++;
    end
    f_q <= forwarded_link_clock;
  end
endmodule
`default_nettype wire

// *** test/tb_pst_serializer.sv ***
// Bench for the 7:1 serialiser: random and walking words, both capture edges.
// Assumes the panel model decodes lanes; the port checker is bound.
`timescale 1ns/1ps
`default_nettype none
module tb_pst_serializer;
  logic sys_clk = 1'b0, resetn = 1'b0, power_down_n = 1'b0, pclk = 1'b0, sel = 1'b1;
  logic [27:0] bits = 28'h0, cur = 28'h0, prev = 28'h0, rx_word;
  logic [3:0] lanes;
  logic lane_oe, fclk, fclk_oe, valid, rx_stb;
  logic [31:0] lfsr = 32'h16;
  int mismatches = 0, check_count = 0;
  pst_serializer i_dut (.sys_clk, .resetn, .power_down_n, .pixel_clock_in(pclk),
    .capture_edge_select(sel), .pixel_bits(bits), .serial_lane(lanes), .serial_lane_oe(lane_oe),
    .forwarded_link_clock(fclk), .forwarded_link_clock_oe(fclk_oe), .lanes_valid(valid));
  pst_link_rx i_rx (.sys_clk, .serial_lane(lanes), .forwarded_link_clock(fclk), .rx_word, .rx_stb);
  initial forever #10 sys_clk = ~sys_clk;
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(logic [27:0] got, logic [27:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One pixel period of seven cycles, data set on the unused edge
  task automatic period(logic [27:0] w);
    @(posedge sys_clk) pclk <= sel;
    repeat (3) @(posedge sys_clk);
    @(posedge sys_clk) begin
      pclk <= ~sel;
      bits <= w;
      prev <= cur;
      cur <= w;
    end
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic run(int n, bit walk);
    repeat (n) begin
      lfsr = nxt(lfsr);
      period(lfsr[27:0]);
    end
    if (walk) for (int i = 0; i < 28; i++) period(28'h1 << i);
  endtask
  task automatic power_up;
    @(posedge sys_clk) power_down_n <= 1'b1;
    run(40, 0);
    chk({27'h0, valid}, 28'h0);
    run(90, 1);
    chk({25'h0, fclk_oe, lane_oe, valid}, 28'h7);
  endtask
  always @(posedge sys_clk) begin
    if (rx_stb === 1'b1 && valid === 1'b1)
      chk(rx_word, prev);
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    power_up();
    @(posedge sys_clk) power_down_n <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk) chk({20'h0, fclk_oe, lane_oe, fclk, valid, lanes}, 28'h0);
    // Edge choice changes only while shut down, so pixel edges stay evenly spaced
    @(posedge sys_clk) sel <= 1'b0;
    power_up();
    run(90, 1);
    print_verdict();
  end
  // About 3050 cycles expected; 200 us is ample
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
